// ===== logic/ioire_controller.sv
/*
 Pin routing controller: select and window registers, routing entries,
 version register, per-pin sensing and a single message sender.
 Assumes a simple synchronous register port, pins synchronous to clk, and a
 system bus side that accepts one message with msg_valid/msg_ready.
*/
// Operation
// - Each entry holds an eight-bit vector, sent in its message except for kinds 100, 101 and 111.
// - Kind 000 sends an ordinary interrupt; vector 0x10 to 0xFF by software.
// - Kind 001 acts as ordinary but marks the message redirectable.
// - Kind 010 drives platform management input; vector up to 0xF, edge. The code senses and flags it by the trigger bit.
// - Kind 100 sends non-maskable interrupt, edge, vector 0x2.
// - Kind 101 asserts soft restart; vector ignored.
// - Kind 111 is legacy controller delivery, vector 0x0, edge only. The code clears the message level flag but senses by the trigger bit.
// - Acknowledge cycle for legacy delivery goes to the legacy controller.
// - Delivery status is read-only: 0 idle, 1 pending.
// - Polarity 0 is active high, 1 active low.
// - Trigger 0 is edge, 1 is level.
// - Unmasked active edge or level delivers a message.
// - Masked pins discard edges and ignore levels.
// - Masking after acceptance does not affect that interrupt.
// - All entries come out of reset masked.
// - Version register low byte holds a hardwired version code.
// - Version register reports zero-based highest entry index.
// - Entries are reached via an eight-bit select and a data window.
// - New edge recognized only after previous delivery completes.
// - End of service on asserted level input sends a fresh message.
`timescale 1ns/1ps
`include "ioire_defs.svh"

module ioire_controller #(
   parameter int NUM_PINS = 24
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   output logic      [31:0]            reg_rdata,
   output logic                        reg_rvalid,
   input  wire logic [NUM_PINS-1:0]    irq_pin,
   output logic                        msg_valid,
   output ioire_pkg::ioire_msg_t       msg,
   input  wire logic                   msg_ready,
   input  wire logic                   ack_cycle,
   output logic                        ack_to_legacy
);

   // --------------------------------------------------------------
   // Register storage
   // --------------------------------------------------------------
   localparam logic [7:0] MAX_ENTRY = 8'(NUM_PINS - 1);
   localparam int         PW = (NUM_PINS > 1) ? $clog2(NUM_PINS) : 1;

   logic [7:0]          select;
   logic [31:0]         entry_lo [NUM_PINS];
   logic [31:0]         entry_hi [NUM_PINS];
   logic [NUM_PINS-1:0] pending;
   logic [NUM_PINS-1:0] eoi_hit;
   logic [NUM_PINS-1:0] delivered;
   logic [NUM_PINS-1:0] level_sel;
   logic                legacy_issued;

   logic                win_entry;
   logic [7:0]          win_off;
   logic [PW-1:0]       win_pin;
   logic                win_hi;

   assign win_off   = select - `IOIRE_IDX_ENTRY_BASE;
   assign win_pin   = win_off[PW:1];
   assign win_hi    = win_off[0];
   assign win_entry = (select >= `IOIRE_IDX_ENTRY_BASE) &&
                      ({1'b0, win_off[7:1]} <= MAX_ENTRY);

   always_ff @(posedge clk) begin
      if (rst)
         select <= 8'h00;
      else if (reg_wr && reg_addr == `IOIRE_OFS_SELECT)
         select <= reg_wdata[7:0];
   end

   // Status bit is never stored: writes cannot reach it
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < NUM_PINS; i++) begin
            entry_lo[i] <= `IOIRE_LO_RESET;
            entry_hi[i] <= `IOIRE_HI_RESET;
         end
      end else if (reg_wr && reg_addr == `IOIRE_OFS_WINDOW && win_entry) begin
         if (win_hi)
            entry_hi[win_pin] <= reg_wdata & `IOIRE_HI_WMASK;
         else
            entry_lo[win_pin] <= reg_wdata & `IOIRE_LO_WMASK;
      end
   end

   // --------------------------------------------------------------
   // Register read
   // --------------------------------------------------------------
   logic [31:0] next_rdata;

   always_comb begin
      next_rdata = 32'h0000_0000;
      if (reg_addr == `IOIRE_OFS_SELECT)
         next_rdata = {24'h00_0000, select};
      else if (reg_addr == `IOIRE_OFS_WINDOW) begin
         if (select == `IOIRE_IDX_VERSION)
            next_rdata = {8'h00, MAX_ENTRY, 8'h00, `IOIRE_VERSION_ID};
         else if (win_entry && win_hi)
            next_rdata = entry_hi[win_pin];
         else if (win_entry) begin
            next_rdata = entry_lo[win_pin];
            next_rdata[`IOIRE_F_STATUS] = pending[win_pin];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata  <= 32'h0000_0000;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_rdata  <= reg_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // --------------------------------------------------------------
   // Pin sensing
   // --------------------------------------------------------------
   for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
      // Non-maskable kind is always sensed on edges, whatever its trigger bit says
      assign level_sel[g] = entry_lo[g][`IOIRE_F_TRIG] &&
                            (entry_lo[g][`IOIRE_F_KIND_LSB +: 3] !=
                             ioire_pkg::IOIRE_KIND_NMI);
      assign eoi_hit[g] = reg_wr && reg_addr == `IOIRE_OFS_EOI &&
                          level_sel[g] &&
                          reg_wdata[7:0] == entry_lo[g][7:0];
      ioire_pin_sense u_sense (
         .clk          (clk),
         .rst          (rst),
         .pin          (irq_pin[g]),
         .polarity_low (entry_lo[g][`IOIRE_F_POL]),
         .level_mode   (level_sel[g]),
         .masked       (entry_lo[g][`IOIRE_F_MASK]),
         .eoi_hit      (eoi_hit[g]),
         .delivered    (delivered[g]),
         .pending      (pending[g])
      );
   end

   // --------------------------------------------------------------
   // Message sender
   // --------------------------------------------------------------
   logic [PW-1:0]          pick;
   logic                   pick_ok;
   ioire_pkg::ioire_msg_t  built;

   always_comb begin
      pick    = '0;
      pick_ok = 1'b0;
      for (int i = NUM_PINS - 1; i >= 0; i--) begin
         if (pending[i]) begin
            pick    = PW'(i);
            pick_ok = 1'b1;
         end
      end
   end

   ioire_msg_build u_build (
      .entry_lo (entry_lo[pick]),
      .entry_hi (entry_hi[pick]),
      .pin_num  (8'(pick)),
      .msg      (built)
   );

   // Once launched, a message completes even if the entry is then masked
   always_ff @(posedge clk) begin
      if (rst) begin
         msg_valid <= 1'b0;
         msg       <= '0;
      end else if (msg_valid) begin
         if (msg_ready)
            msg_valid <= 1'b0;
      end else if (pick_ok && !delivered[pick]) begin
         msg_valid <= 1'b1;
         msg       <= built;
      end
   end

   always_comb begin
      delivered = '0;
      if (msg_valid && msg_ready)
         delivered[msg.pin[PW-1:0]] = 1'b1;
   end

   // --------------------------------------------------------------
   // Legacy acknowledge routing
   // --------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst)
         legacy_issued <= 1'b0;
      else if (msg_valid && msg_ready && msg.kind == ioire_pkg::IOIRE_KIND_LEGACY)
         legacy_issued <= 1'b1;
      else if (ack_cycle)
         legacy_issued <= 1'b0;
   end

   always_ff @(posedge clk) begin
      if (rst)
         ack_to_legacy <= 1'b0;
      else
         ack_to_legacy <= ack_cycle && legacy_issued;
   end

   // --------------------------------------------------------------
   // Checks
   // --------------------------------------------------------------
   a_nmi_vector: assert property (@(posedge clk) disable iff (rst)
      (msg_valid && msg.kind == ioire_pkg::IOIRE_KIND_NMI) |->
      (msg.vector == 8'h02 && !msg.level))
      else $error("nmi vector wrong");
   a_legacy_vec: assert property (@(posedge clk) disable iff (rst)
      (msg_valid && msg.kind == ioire_pkg::IOIRE_KIND_LEGACY) |-> msg.vector == 8'h00)
      else $error("legacy vector not zero");
   a_restart_vec: assert property (@(posedge clk) disable iff (rst)
      (msg_valid && msg.kind == ioire_pkg::IOIRE_KIND_RESTART) |-> msg.vector == 8'h00)
      else $error("restart vector not ignored");
   a_msg_hold: assert property (@(posedge clk) disable iff (rst)
      (msg_valid && !msg_ready) |=> (msg_valid && $stable(msg)))
      else $error("message dropped before acceptance");
   a_redir_flag: assert property (@(posedge clk) disable iff (rst)
      msg_valid |-> (msg.redirectable == (msg.kind == ioire_pkg::IOIRE_KIND_REDIR)))
      else $error("redirect flag wrong");
   a_msg_launch: assert property (@(posedge clk) disable iff (rst)
      (!msg_valid && pick_ok) |=> (msg_valid && msg.pin[PW-1:0] == $past(pick)))
      else $error("pending pin not offered");
   a_reset_mask: assert property (@(posedge clk) disable iff (rst)
      $past(rst) |-> entry_lo[0][`IOIRE_F_MASK])
      else $error("entry not masked after reset");
   a_select_write: assert property (@(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == `IOIRE_OFS_SELECT) |=> select == $past(reg_wdata[7:0]))
      else $error("select not written");
   a_read_answer: assert property (@(posedge clk) disable iff (rst)
      reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_read_idle: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> (!reg_rvalid && reg_rdata == 32'h0000_0000))
      else $error("read data without read");
   a_status_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == `IOIRE_OFS_WINDOW && win_entry && !win_hi) |=>
      reg_rdata[`IOIRE_F_STATUS] == $past(pending[win_pin]))
      else $error("status bit wrong");
   a_hi_reserved: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == `IOIRE_OFS_WINDOW && win_entry && win_hi) |=>
      reg_rdata[15:0] == 16'h0000)
      else $error("reserved bits not zero");
   a_version_read: assert property (@(posedge clk) disable iff (rst)
      (reg_rd && reg_addr == 8'h10 && select == 8'h01) |=>
      (reg_rvalid && reg_rdata == {8'h00, MAX_ENTRY, 8'h00, 8'h5A}))
      else $error("version read wrong");
   a_ack_route: assert property (@(posedge clk) disable iff (rst)
      (ack_cycle && legacy_issued) |=> ack_to_legacy)
      else $error("acknowledge not routed");
   a_ack_stray: assert property (@(posedge clk) disable iff (rst)
      (ack_cycle && !legacy_issued) |=> !ack_to_legacy)
      else $error("stray acknowledge routed");

   c_fixed_msg: cover property (@(posedge clk) disable iff (rst)
      msg_valid && msg_ready && msg.kind == ioire_pkg::IOIRE_KIND_FIXED);
   c_nmi_msg: cover property (@(posedge clk) disable iff (rst)
      msg_valid && msg_ready && msg.kind == ioire_pkg::IOIRE_KIND_NMI);
   c_level_eoi: cover property (@(posedge clk) disable iff (rst) |eoi_hit);
   c_legacy_ack: cover property (@(posedge clk) disable iff (rst) ack_to_legacy);
   c_status_seen: cover property (@(posedge clk) disable iff (rst)
      reg_rvalid && reg_rdata[`IOIRE_F_STATUS]);

endmodule

// ===== logic/ioire_msg_build.sv
/*
 Builds an outgoing interrupt message from a routing entry. Assumes the
 entry low and high words are stable while read.
*/
`timescale 1ns/1ps
`include "ioire_defs.svh"

module ioire_msg_build (
   input  wire logic [31:0]       entry_lo,
   input  wire logic [31:0]       entry_hi,
   input  wire logic [7:0]        pin_num,
   output ioire_pkg::ioire_msg_t  msg
);

   ioire_pkg::ioire_kind_t kind;

   assign kind = ioire_pkg::ioire_kind_t'(entry_lo[`IOIRE_F_KIND_LSB +: 3]);

   always_comb begin
      msg              = '0;
      msg.target       = entry_hi[`IOIRE_F_TGT_LSB +: 8];
      msg.ext_target   = entry_hi[`IOIRE_F_EXT_LSB +: 8];
      msg.vector       = entry_lo[`IOIRE_F_VEC_LSB +: 8];
      msg.kind         = kind;
      msg.pin          = pin_num;
      msg.level        = entry_lo[`IOIRE_F_TRIG];
      msg.redirectable = (kind == ioire_pkg::IOIRE_KIND_REDIR);
      unique case (kind)
         ioire_pkg::IOIRE_KIND_NMI: begin
            msg.vector = `IOIRE_VEC_NMI;
            msg.level  = 1'b0;
         end
         ioire_pkg::IOIRE_KIND_RESTART: begin
            msg.vector = 8'h00;
            msg.level  = 1'b0;
         end
         ioire_pkg::IOIRE_KIND_LEGACY: begin
            msg.vector = `IOIRE_VEC_LEGACY;
            msg.level  = 1'b0;
         end
         default: begin
         end
      endcase
   end

endmodule

// ===== logic/ioire_pin_sense.sv
/*
 One interrupt pin front end: polarity, edge or level sensing, masking and
 the pending flag. Assumes the pin is synchronous to clk.
*/
`timescale 1ns/1ps
`include "ioire_defs.svh"

module ioire_pin_sense (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic pin,
   input  wire logic polarity_low,
   input  wire logic level_mode,
   input  wire logic masked,
   input  wire logic eoi_hit,
   input  wire logic delivered,
   output logic      pending
);

   logic active;
   logic active_q;
   logic level_armed;

   assign active = pin ^ polarity_low;

   always_ff @(posedge clk) begin
      if (rst)
         active_q <= 1'b0;
      else
         active_q <= active;
   end

   // Level re-arms only on end of service, so one assertion gives one message
   always_ff @(posedge clk) begin
      if (rst)
         level_armed <= 1'b1;
      else if (eoi_hit)
         level_armed <= 1'b1;
      else if (delivered && level_mode)
         level_armed <= 1'b0;
      else if (!level_mode)
         level_armed <= 1'b1;
   end

   always_ff @(posedge clk) begin
      if (rst)
         pending <= 1'b0;
      else if (masked && !pending)
         pending <= 1'b0;
      else if (!pending && !masked) begin
         if (level_mode)
            pending <= active && level_armed;
         else
            pending <= active && !active_q;
      end else if (delivered)
         pending <= 1'b0;
   end

   a_edge_take: assert property (@(posedge clk) disable iff (rst)
      (!level_mode && !masked && !pending && active && !active_q) |=> pending)
      else $error("unmasked edge not taken");
   a_mask_drop: assert property (@(posedge clk) disable iff (rst)
      (masked && !pending) |=> !pending)
      else $error("masked pin went pending");
   a_pend_hold: assert property (@(posedge clk) disable iff (rst)
      (pending && !delivered) |=> pending)
      else $error("pending lost before delivery");

endmodule

// ===== pkg/ioire_defs.svh
/*
 Holds offsets, field positions, reset values and identity constants of the
 pin routing controller. Assumes it is included by its bare name.
*/
`ifndef IOIRE_DEFS_SVH
`define IOIRE_DEFS_SVH

// --------------------------------------------------------------
// Direct and indirect register offsets
// --------------------------------------------------------------
`define IOIRE_OFS_SELECT     8'h00
`define IOIRE_OFS_WINDOW     8'h10
`define IOIRE_OFS_EOI        8'h40
`define IOIRE_IDX_VERSION    8'h01
`define IOIRE_IDX_ENTRY_BASE 8'h10

// --------------------------------------------------------------
// Routing entry field positions
// --------------------------------------------------------------
`define IOIRE_F_VEC_LSB      0
`define IOIRE_F_KIND_LSB     8
`define IOIRE_F_STATUS       12
`define IOIRE_F_POL          13
`define IOIRE_F_TRIG         15
`define IOIRE_F_MASK         16
`define IOIRE_F_EXT_LSB      16
`define IOIRE_F_TGT_LSB      24
`define IOIRE_LO_WMASK       32'h0001_A7FF
`define IOIRE_HI_WMASK       32'hFFFF_0000

// --------------------------------------------------------------
// Reset values and fixed vectors
// --------------------------------------------------------------
`define IOIRE_LO_RESET       32'h0001_0000
`define IOIRE_HI_RESET       32'h0000_0000
`define IOIRE_VEC_NMI        8'h02
`define IOIRE_VEC_LEGACY     8'h00
// Version code value is arbitrary
`define IOIRE_VERSION_ID     8'h5A

`endif

// ===== pkg/ioire_pkg.sv
/*
 Types of the pin routing controller. Assumes nothing of its surroundings.
*/
package ioire_pkg;

   typedef enum logic [2:0] {
      IOIRE_KIND_FIXED    = 3'b000,
      IOIRE_KIND_REDIR    = 3'b001,
      IOIRE_KIND_PLATFORM = 3'b010,
      IOIRE_KIND_RSVD3    = 3'b011,
      IOIRE_KIND_NMI      = 3'b100,
      IOIRE_KIND_RESTART  = 3'b101,
      IOIRE_KIND_RSVD6    = 3'b110,
      IOIRE_KIND_LEGACY   = 3'b111
   } ioire_kind_t;

   typedef struct packed {
      logic [7:0]  target;
      logic [7:0]  ext_target;
      logic [7:0]  vector;
      ioire_kind_t kind;
      logic        redirectable;
      logic        level;
      logic [7:0]  pin;
   } ioire_msg_t;

endpackage

// ===== verification/ioire_cpu_model.sv
/*
 Processor side model: accepts interrupt messages, promptly or after a stall.
 Assumes one clock and the controller's msg_valid/msg_ready handshake.
*/
`timescale 1ns/1ps

module ioire_cpu_model #(
   parameter logic [7:0] OWN_TARGET = 8'h3C,
   parameter logic [7:0] OWN_EXT    = 8'h00
) (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  msg_valid,
   input  wire ioire_pkg::ioire_msg_t msg,
   input  wire logic [7:0]            stall,
   output logic                       msg_ready,
   output logic                       for_me
);
   logic [7:0] waited;

   // --------------------------------------------------------------
   // Acceptance
   // --------------------------------------------------------------
   // Ready rises only after the offer is seen, so a slow receiver is exercised
   always_ff @(posedge clk) begin
      if (rst || !msg_valid || msg_ready) begin
         msg_ready <= 1'b0;
         waited    <= 8'h00;
      end else begin
         waited    <= waited + 8'h01;
         msg_ready <= (waited >= stall);
      end
   end

   // Destination match against own identifiers
   assign for_me = msg_valid && msg.target == OWN_TARGET && msg.ext_target == OWN_EXT;
endmodule

// ===== verification/test_ioire_controller.sv
/*
 Self-checking bench of the pin routing controller with a processor model.
 Assumes the controller answers reads one cycle late and offers one message
 at a time.
*/
`timescale 1ns/1ps
`include "ioire_defs.svh"

module test_ioire_controller;
   localparam int          NP   = 8;
   localparam logic [63:0] NONE = 64'hF000_0000_0000_0000;
   logic                  clk       = 1'b0;
   logic                  rst       = 1'b1;
   logic                  reg_wr    = 1'b0;
   logic                  reg_rd    = 1'b0;
   logic                  ack_cycle = 1'b0;
   logic [7:0]            reg_addr  = 8'h00;
   logic [7:0]            stall     = 8'h00;
   logic [31:0]           reg_wdata = 32'h0000_0000;
   logic [NP-1:0]         irq_pin   = '0;
   logic [31:0]           reg_rdata;
   logic                  reg_rvalid;
   logic                  msg_valid;
   logic                  msg_ready;
   logic                  ack_to_legacy;
   logic                  for_me;
   ioire_pkg::ioire_msg_t msg;
   ioire_pkg::ioire_msg_t msg_q[$];
   logic [31:0]           rd_q[$];
   logic [2:0]            kinds[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h7};
   int                    err_total       = 0;
   int                    samples_checked = 0;
   int                    acks_seen       = 0;

   always #20 clk = ~clk;

   ioire_controller #(.NUM_PINS(NP)) ioire_controller_inst (
      .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .irq_pin(irq_pin), .msg_valid(msg_valid), .msg(msg), .msg_ready(msg_ready),
      .ack_cycle(ack_cycle), .ack_to_legacy(ack_to_legacy));

   ioire_cpu_model ioire_cpu_model_inst (
      .clk(clk), .rst(rst), .msg_valid(msg_valid), .msg(msg), .stall(stall),
      .msg_ready(msg_ready), .for_me(for_me));

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      rd_q.push_back(e);
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask

   task automatic rdi(input logic [7:0] idx, input logic [31:0] e);
      wr(`IOIRE_OFS_SELECT, {24'h0, idx});
      rd(`IOIRE_OFS_WINDOW, e);
   endtask

   // Mask first, then the destination half, then the low word as wanted
   task automatic setent(input int n, input logic [31:0] lo, input logic [31:0] hi);
      wr(`IOIRE_OFS_SELECT, {24'h0, 8'h10 + 8'(2 * n)});
      wr(`IOIRE_OFS_WINDOW, lo | 32'h0001_0000);
      wr(`IOIRE_OFS_SELECT, {24'h0, 8'h11 + 8'(2 * n)});
      wr(`IOIRE_OFS_WINDOW, hi);
      wr(`IOIRE_OFS_SELECT, {24'h0, 8'h10 + 8'(2 * n)});
      wr(`IOIRE_OFS_WINDOW, lo);
   endtask

   function automatic ioire_pkg::ioire_msg_t mk(input int n, input logic [31:0] lo,
                                                input logic [31:0] hi);
      ioire_pkg::ioire_msg_t m;
      m.target       = hi[31:24];
      m.ext_target   = hi[23:16];
      m.kind         = ioire_pkg::ioire_kind_t'(lo[10:8]);
      m.redirectable = (lo[10:8] == 3'b001);
      m.level        = lo[15] && (lo[10:8] != 3'b100) &&
                       (lo[10:8] != 3'b101) && (lo[10:8] != 3'b111);
      m.pin          = 8'(n);
      case (lo[10:8])
         3'b100:         m.vector = 8'h02;
         3'b101, 3'b111: m.vector = 8'h00;
         default:        m.vector = lo[7:0];
      endcase
      return m;
   endfunction

   task automatic pulse(input int n);
      @(posedge clk);
      irq_pin[n] <= ~irq_pin[n];
      @(posedge clk);
      irq_pin[n] <= ~irq_pin[n];
   endtask

   task automatic endt(input string s);
      for (int i = 0; i < 400 && (msg_q.size() != 0 || rd_q.size() != 0); i++) @(posedge clk);
      if (msg_q.size() != 0 || rd_q.size() != 0) begin
         err_total++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, msg_q.size() + rd_q.size(), 0);
         msg_q.delete();
         rd_q.delete();
      end
      repeat (6) @(posedge clk);
      $display("test %s done", s);
   endtask

   task automatic stop_test;
      $display("Checks %0d, mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // --------------------------------------------------------------
   // Monitor
   // --------------------------------------------------------------
   // An answer with no note queued can never match the marker value
   always @(posedge clk) begin : mon
      logic [63:0] em;
      if (!rst) begin
         if (reg_rvalid) chk(reg_rdata, rd_q.size() ? {32'h0, rd_q.pop_front()} : NONE);
         if (msg_valid && msg_ready) begin
            em = msg_q.size() ? 64'(msg_q.pop_front()) : NONE;
            chk(64'(msg), em);
            chk(64'(for_me), 64'(em[36:21] == 16'h3C00));
         end
         if (ack_to_legacy) acks_seen++;
      end
   end

   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      stop_test;
   end

   // --------------------------------------------------------------
   // Tests
   // --------------------------------------------------------------
   initial begin
      logic [31:0] lo;
      logic [31:0] hi;
      logic [7:0]  v;
      void'($urandom(32'h580604D8));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      for (int n = 0; n < NP; n++) begin
         rdi(8'h10 + 8'(2 * n), 32'h0001_0000);
         rdi(8'h11 + 8'(2 * n), 32'h0000_0000);
      end
      rdi(`IOIRE_IDX_VERSION, {8'h00, 8'(NP - 1), 8'h00, `IOIRE_VERSION_ID});
      rdi(8'h02, 32'h0000_0000);
      rdi(8'h10 + 8'(2 * NP), 32'h0000_0000);
      rd(8'h20, 32'h0000_0000);
      endt("reset");
      setent(7, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rdi(8'h1E, 32'h0001_A7FF);
      rdi(8'h1F, 32'hFFFF_0000);
      endt("fields");
      // One legacy source only, on entry 5
      for (int k = 0; k < 6; k++) begin
         v  = (kinds[k] == 3'h2) ? 8'($urandom % 16) : 8'h10 + 8'($urandom % 240);
         hi = $urandom & 32'hFFFF_0000;
         lo = {16'h0, kinds[k] == 3'h4, 4'h0, kinds[k], v};
         setent(k, lo, hi);
         msg_q.push_back(mk(k, lo, hi));
         pulse(k);
         endt("kind");
      end
      @(posedge clk) ack_cycle <= 1'b1;
      @(posedge clk) ack_cycle <= 1'b0;
      repeat (3) @(posedge clk);
      chk(acks_seen, 1);
      @(posedge clk) ack_cycle <= 1'b1;
      @(posedge clk) ack_cycle <= 1'b0;
      repeat (3) @(posedge clk);
      chk(acks_seen, 1);
      endt("ack");
      setent(6, 32'h0001_0040, 32'h0);
      pulse(6);
      wr(`IOIRE_OFS_WINDOW, 32'h0000_0040);
      endt("mask");
      lo = 32'h0001_2055;
      setent(6, lo, 32'h0);
      @(posedge clk) irq_pin[6] <= 1'b1;
      wr(`IOIRE_OFS_WINDOW, 32'h0000_2055);
      msg_q.push_back(mk(6, 32'h0000_2055, 32'h0));
      pulse(6);
      endt("polarity");
      stall <= 8'd20;
      setent(0, 32'h0000_0091, 32'h3C00_0000);
      msg_q.push_back(mk(0, 32'h0000_0091, 32'h3C00_0000));
      pulse(0);
      rdi(8'h10, 32'h0000_1091);
      pulse(0);
      wr(`IOIRE_OFS_WINDOW, 32'h0001_0091);
      endt("pending");
      stall <= 8'd0;
      wr(`IOIRE_OFS_WINDOW, 32'h0000_0091);
      msg_q.push_back(mk(0, 32'h0000_0091, 32'h3C00_0000));
      pulse(0);
      endt("rearm");
      lo = 32'h0000_8077;
      setent(3, lo, 32'h1100_0000);
      msg_q.push_back(mk(3, lo, 32'h1100_0000));
      @(posedge clk) irq_pin[3] <= 1'b1;
      endt("level");
      msg_q.push_back(mk(3, lo, 32'h1100_0000));
      wr(`IOIRE_OFS_EOI, 32'h0000_0077);
      endt("eoi");
      @(posedge clk) irq_pin[3] <= 1'b0;
      wr(`IOIRE_OFS_EOI, 32'h0000_0077);
      endt("eoi idle");
      @(posedge clk) rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdi(8'h1C, 32'h0001_0000);
      endt("reset again");
      stop_test;
   end
endmodule
